/* src/rf_atten_detect_cmd_handler.v */
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rf_cmd_consts.vh"

// Summary of operation
// R1: Each protocol keeps an attenuation from 0 to 15 dB in 1 dB steps.
// R2: The host sets attenuation with 0x51, protocol byte, attenuation byte, 0x0D.
// R3: Downlink attenuation is the upper nibble and uplink the lower nibble.
// R4: Protocol code sits in the upper nibble, lower nibble zero; 2, 3, 4, 8 are valid.
// R5: Set attenuation answers 0x51, protocol echo, status byte with zero upper nibble, 0x0D.
// R6: The host reads attenuation with 0x52, protocol byte, 0x0D.
// R7: Get attenuation answers 0x52, protocol echo, attenuation, status, 0x0D.
// R8: The attenuation read back is the last one written for that protocol.
// R9: Each protocol keeps its own detect threshold of up to 20 dB in 1 dB steps.
// R10: A tag response is forwarded only when its level exceeds that protocol's threshold.
// R11: The host sets the threshold with 0x53, protocol byte, value 0 to 20, 0x0D.
// R12: Set detect answers 0x53, protocol echo, acknowledge, 0x0D.
// R13: An acknowledge byte of 0 accepts and 1 rejects.
// R14: The host reads the threshold with 0x54, protocol byte, 0x0D.
// R15: Get detect answers 0x54, protocol echo, threshold, acknowledge, 0x0D.
// R16: Bad protocol codes or thresholds above 20 are rejected and change nothing.
// R17: A frame without its carriage return is dropped; an opcode there starts a new frame.

module rf_atten_detect_cmd_handler (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  output reg         irq,
  input  wire        tag_valid,
  input  wire [1:0]  tag_proto,
  input  wire [4:0]  tag_level,
  input  wire [7:0]  tag_data,
  output reg         fwd_valid,
  output reg  [7:0]  fwd_data,
  output wire [31:0] atten_set,
  output wire [19:0] detect_thr
);

  // ----------------------------------------------------------------
  // Parser states
  // ----------------------------------------------------------------
  localparam [1:0] S_IDLE  = 2'h0;
  localparam [1:0] S_PROTO = 2'h1;
  localparam [1:0] S_ARG   = 2'h2;
  localparam [1:0] S_CR    = 2'h3;

  reg  [7:0] aw_addr_r;
  reg        aw_held_r;
  reg  [31:0] w_data_r;
  reg  [3:0] w_strb_r;
  reg        w_held_r;
  reg  [1:0] pst_r;
  reg  [7:0] op_r;
  reg  [7:0] proto_r;
  reg  [7:0] arg_r;
  reg  [7:0] rbuf_r [0:4];
  reg  [2:0] rlen_r;
  reg  [2:0] rptr_r;
  reg  [2:0] stat_r;
  reg  [2:0] mask_r;
  reg  [2:0] stat_nxt;
  reg  [2:0] mask_nxt;
  reg  [1:0] pidx;
  reg        pok;
  reg  [7:0] rb2;
  reg  [7:0] rb3;
  reg  [7:0] rb4;
  reg  [2:0] rlen_nxt;
  reg  [31:0] rd_mux;
  reg        rd_err;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire       wr_go    = aw_held_r & w_held_r & ~bvalid;
  wire [7:0] wr_ofs   = {aw_addr_r[7:2], 2'b00};
  wire       wr_cmd   = wr_go & (wr_ofs == `OFS_CMD);
  wire       wr_stat  = wr_go & (wr_ofs == `OFS_STAT) & w_strb_r[0];
  wire       wr_mask  = wr_go & (wr_ofs == `OFS_MASK) & w_strb_r[0];
  wire       wr_known = wr_cmd | (wr_go & ((wr_ofs == `OFS_STAT) | (wr_ofs == `OFS_MASK)));
  // New command bytes are refused until the pending answer is drained
  wire       cmd_push = wr_cmd & w_strb_r[0] & (rlen_r == 3'h0);
  wire [7:0] cbyte    = w_data_r[7:0];
  wire       is_op    = (cbyte >= `OP_SET_ATT) && (cbyte <= `OP_GET_DET);
  wire       is_set   = (op_r == `OP_SET_ATT) || (op_r == `OP_SET_DET);

  // ----------------------------------------------------------------
  // Frame close and validation
  // ----------------------------------------------------------------
  wire       at_cr    = cmd_push & (pst_r == S_CR);
  wire       frame_ok = at_cr & (cbyte == `BYTE_CR);
  wire       frame_er = at_cr & (cbyte != `BYTE_CR); // R17
  wire       thr_ok   = arg_r <= {3'h0, `THR_MAX}; // R11
  wire       reject   = ~pok | ((op_r == `OP_SET_DET) & ~thr_ok); // R16
  wire [7:0] ackb     = reject ? `ACK_REJ : `ACK_OK; // R13 R5
  wire [7:0] att_sel  = atten_set[{pidx, 3'b000} +: 8];
  wire [4:0] thr_sel  = detect_thr[pidx * 5 +: 5];
  wire       exec     = frame_ok & ~reject;

  // Protocol byte to slot index; lower nibble must be clear
  always @* begin
    pidx = 2'h0;
    pok  = 1'b0;
    if (proto_r[3:0] == 4'h0) begin // R4
      case (proto_r[7:4])
        `PROTO_SEL_A: begin pidx = 2'h0; pok = 1'b1; end
        `PROTO_SEL_B: begin pidx = 2'h1; pok = 1'b1; end
        `PROTO_SEL_C: begin pidx = 2'h2; pok = 1'b1; end
        `PROTO_SEL_D: begin pidx = 2'h3; pok = 1'b1; end
        default: begin pidx = 2'h0; pok = 1'b0; end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Settings slots, one per protocol
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : slot
      proto_slot u_slot (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_att  (exec & (op_r == `OP_SET_ATT) & (pidx == gi)), // R8
        .wr_thr  (exec & (op_r == `OP_SET_DET) & (pidx == gi)), // R9
        .din     (arg_r),
        .att_r   (atten_set[gi*8 +: 8]),
        .thr_r   (detect_thr[gi*5 +: 5])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Answer frame contents
  // ----------------------------------------------------------------
  // Rejected reads return zero data so stale slots never leak out
  always @* begin
    case (op_r)
      `OP_SET_ATT, `OP_SET_DET: begin
        rb2      = ackb; // R5 R12
        rb3      = `BYTE_CR;
        rb4      = 8'h00;
        rlen_nxt = `RESP_LEN_SET;
      end
      `OP_GET_ATT: begin
        rb2      = reject ? 8'h00 : att_sel; // R7 R8
        rb3      = ackb;
        rb4      = `BYTE_CR;
        rlen_nxt = `RESP_LEN_GET;
      end
      default: begin
        rb2      = reject ? 8'h00 : {3'h0, thr_sel}; // R15
        rb3      = ackb;
        rb4      = `BYTE_CR;
        rlen_nxt = `RESP_LEN_GET;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Byte parser and answer buffer
  // ----------------------------------------------------------------
  wire ar_go    = arvalid & arready;
  wire [7:0] rd_ofs = {araddr[7:2], 2'b00};
  wire pop      = ar_go & (rd_ofs == `OFS_RESP) & (rlen_r != 3'h0);

  always @(posedge aclk) begin
    if (!aresetn) begin
      pst_r    <= S_IDLE;
      op_r     <= 8'h00;
      proto_r  <= 8'h00;
      arg_r    <= 8'h00;
      rlen_r   <= 3'h0;
      rptr_r   <= 3'h0;
      rbuf_r[0] <= 8'h00;
      rbuf_r[1] <= 8'h00;
      rbuf_r[2] <= 8'h00;
      rbuf_r[3] <= 8'h00;
      rbuf_r[4] <= 8'h00;
    end else begin
      if (cmd_push) begin
        case (pst_r)
          S_IDLE: begin
            if (is_op) begin // R17
              op_r  <= cbyte;
              pst_r <= S_PROTO;
            end
          end
          S_PROTO: begin
            proto_r <= cbyte;
            pst_r   <= is_set ? S_ARG : S_CR; // R2 R6 R11 R14
          end
          S_ARG: begin
            arg_r <= cbyte;
            pst_r <= S_CR;
          end
          S_CR: begin
            if (cbyte == `BYTE_CR) begin
              pst_r <= S_IDLE;
            end else if (is_op) begin // R17
              op_r  <= cbyte;
              pst_r <= S_PROTO;
            end else begin
              pst_r <= S_IDLE;
            end
          end
          default: pst_r <= S_IDLE;
        endcase
      end
      // Every complete frame is answered, accepted or not
      if (frame_ok) begin
        rbuf_r[0] <= op_r; // R5 R7 R12 R15
        rbuf_r[1] <= proto_r;
        rbuf_r[2] <= rb2;
        rbuf_r[3] <= rb3;
        rbuf_r[4] <= rb4;
        rlen_r    <= rlen_nxt;
        rptr_r    <= 3'h0;
      end else if (pop) begin
        if (rptr_r + 3'h1 == rlen_r) begin
          rlen_r <= 3'h0;
          rptr_r <= 3'h0;
        end else begin
          rptr_r <= rptr_r + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, mask, interrupt
  // ----------------------------------------------------------------
  // Hardware set beats a write-one clear in the same cycle
  always @* begin
    stat_nxt = stat_r & ~(wr_stat ? w_data_r[2:0] : 3'h0);
    stat_nxt[`ST_RESP_RDY]  = stat_nxt[`ST_RESP_RDY] | frame_ok;
    stat_nxt[`ST_FRAME_ERR] = stat_nxt[`ST_FRAME_ERR] | frame_er;
    stat_nxt[`ST_REJECT]    = stat_nxt[`ST_REJECT] | (frame_ok & reject);
    mask_nxt = wr_mask ? w_data_r[2:0] : mask_r;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= `STAT_RESET;
      mask_r <= `MASK_RESET;
      irq    <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq    <= |(stat_nxt & mask_nxt);
    end
  end

  // ----------------------------------------------------------------
  // Detect gate
  // ----------------------------------------------------------------
  // Tag inputs come from the same clock, so no synchroniser here
  always @(posedge aclk) begin
    if (!aresetn) begin
      fwd_valid <= 1'b0;
      fwd_data  <= 8'h00;
    end else begin
      fwd_valid <= tag_valid & (tag_level > detect_thr[tag_proto * 5 +: 5]); // R10
      fwd_data  <= tag_data;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `AXI_OKAY;
    end else begin
      if (awvalid & awready) begin
        aw_addr_r <= awaddr;
        aw_held_r <= 1'b1;
        awready   <= 1'b0;
      end
      if (wvalid & wready) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        w_held_r <= 1'b1;
        wready   <= 1'b0;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid    <= 1'b1;
        // Refused command byte or unmapped offset reports SLVERR
        bresp     <= (~wr_known | (wr_cmd & ~cmd_push)) ? `AXI_SLVERR : `AXI_OKAY;
      end
      if (bvalid & bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  always @* begin
    rd_err = 1'b0;
    case (rd_ofs)
      `OFS_CMD:  rd_mux = 32'h00000000;
      `OFS_RESP: rd_mux = {23'h000000, rlen_r != 3'h0, rbuf_r[rptr_r]};
      `OFS_STAT: rd_mux = {29'h00000000, stat_r};
      `OFS_MASK: rd_mux = {29'h00000000, mask_r};
      `OFS_INFO: rd_mux = {24'h000000, rptr_r, rlen_r, pst_r};
      default: begin
        rd_mux = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `AXI_OKAY;
    end else begin
      if (ar_go) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_mux;
        rresp   <= rd_err ? `AXI_SLVERR : `AXI_OKAY;
      end else if (rvalid & rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* pkg/rf_cmd_consts.vh */
`ifndef RF_CMD_CONSTS_VH
`define RF_CMD_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CMD      8'h00
`define OFS_RESP     8'h04
`define OFS_STAT     8'h08
`define OFS_MASK     8'h0C
`define OFS_INFO     8'h10

// ----------------------------------------------------------------
// Frame bytes
// ----------------------------------------------------------------
`define OP_SET_ATT   8'h51
`define OP_GET_ATT   8'h52
`define OP_SET_DET   8'h53
`define OP_GET_DET   8'h54
`define BYTE_CR      8'h0D
`define ACK_OK       8'h00
`define ACK_REJ      8'h01

// ----------------------------------------------------------------
// Protocol selector codes, upper nibble of protocol byte
// ----------------------------------------------------------------
`define PROTO_SEL_A  4'h2
`define PROTO_SEL_B  4'h3
`define PROTO_SEL_C  4'h4
`define PROTO_SEL_D  4'h8

// ----------------------------------------------------------------
// Limits, field positions, reset values
// ----------------------------------------------------------------
`define THR_MAX      5'h14
`define DL_ATT_MSB   7
`define UL_ATT_LSB   0
`define ST_RESP_RDY  0
`define ST_FRAME_ERR 1
`define ST_REJECT    2
`define STAT_RESET   3'h0
`define MASK_RESET   3'h0
`define SLOT_RESET   8'h00
`define RESP_LEN_SET 3'h4
`define RESP_LEN_GET 3'h5
`define AXI_OKAY     2'h0
`define AXI_SLVERR   2'h2

`endif

/* src/proto_slot.v */
`timescale 1ns/1ps
`default_nettype none
`include "rf_cmd_consts.vh"

module proto_slot (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       wr_att,
  input  wire       wr_thr,
  input  wire [7:0] din,
  output reg  [7:0] att_r,
  output reg  [4:0] thr_r
);

  // ----------------------------------------------------------------
  // Per-protocol settings
  // ----------------------------------------------------------------
  // Attenuation byte kept whole: both nibbles span 0..15 dB
  always @(posedge aclk) begin
    if (!aresetn) begin
      att_r <= `SLOT_RESET;
      thr_r <= 5'h00;
    end else begin
      if (wr_att) begin
        att_r <= din; // R1 R3 R8
      end
      if (wr_thr) begin
        thr_r <= din[4:0]; // R9
      end
    end
  end

endmodule
`default_nettype wire

/* tb/rf_cmd_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Bus handshake and tag gate checks
// ----------------------------
module rf_cmd_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        tag_valid,
  input wire logic [1:0]  tag_proto,
  input wire logic [4:0]  tag_level,
  input wire logic [7:0]  tag_data,
  input wire logic        fwd_valid,
  input wire logic [7:0]  fwd_data,
  input wire logic [19:0] detect_thr
);
  wire [4:0] thr_sel;
  // Threshold of the slot named by the tag
  assign thr_sel = detect_thr[tag_proto*5 +: 5];
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence tag_hot;
    tag_valid && (tag_level > thr_sel);
  endsequence
  sequence tag_cold;
    tag_valid && (tag_level <= thr_sel);
  endsequence
  a_write_answered: assert property (wr_taken |-> ##2 bvalid)
    else $error("write response missing");
  a_read_answered: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_one_write: assert property (bvalid |-> !awready && !wready)
    else $error("second write accepted");
  a_one_read: assert property (rvalid |-> !arready)
    else $error("second read accepted");
  a_fwd_passes: assert property (tag_hot |=> fwd_valid && fwd_data == $past(tag_data))
    else $error("tag above threshold not forwarded");
  a_fwd_blocked: assert property (tag_cold |=> !fwd_valid)
    else $error("tag at or below threshold forwarded");
  a_fwd_pulse: assert property (!tag_valid |=> !fwd_valid)
    else $error("forward without tag");
  a_thr_limit: assert property (detect_thr[4:0] <= 5'h14 && detect_thr[9:5] <= 5'h14 &&
    detect_thr[14:10] <= 5'h14 && detect_thr[19:15] <= 5'h14)
    else $error("threshold above limit");
endmodule
bind rf_atten_detect_cmd_handler rf_cmd_checker chk_u (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .tag_valid(tag_valid), .tag_proto(tag_proto), .tag_level(tag_level), .tag_data(tag_data),
  .fwd_valid(fwd_valid), .fwd_data(fwd_data), .detect_thr(detect_thr)
);
`default_nettype wire

/* tb/host_cmd_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rf_cmd_consts.vh"
// ----------------------------
// Host side: frames over the register bus
// ----------------------------
module host_cmd_model (
  input  wire logic        aclk,
  output var  logic [7:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [7:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end
  // Address and data may be taken at different edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1;
    w = 1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Whole frame, one byte per write; gets carry no argument
  task automatic send(input logic [7:0] op, input logic [7:0] p, input logic [7:0] a,
                      input bit set);
    logic [1:0] r;
    wr(`OFS_CMD, {24'h0, op}, r);
    wr(`OFS_CMD, {24'h0, p}, r);
    if (set) wr(`OFS_CMD, {24'h0, a}, r);
    wr(`OFS_CMD, {24'h0, `BYTE_CR}, r);
  endtask
endmodule
`default_nettype wire

/* tb/rf_atten_detect_cmd_handler_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rf_cmd_consts.vh"
module rf_atten_detect_cmd_handler_bench;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, tag_valid, fwd_valid;
  logic [7:0] awaddr, araddr, tag_data, fwd_data;
  logic [31:0] wdata, rdata, atten_set, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, tag_proto, r;
  logic [4:0] tag_level;
  logic [19:0] detect_thr;
  logic [7:0] pr [4] = '{8'h20, 8'h30, 8'h40, 8'h80};
  int n_errors, check_count;
  rf_atten_detect_cmd_handler dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq), .tag_valid(tag_valid), .tag_proto(tag_proto),
    .tag_level(tag_level), .tag_data(tag_data), .fwd_valid(fwd_valid), .fwd_data(fwd_data),
    .atten_set(atten_set), .detect_thr(detect_thr));
  host_cmd_model host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // ----------------------------
  // Shared helpers
  // ----------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Pop n answer bytes, first byte in the top position
  task automatic ans(input logic [39:0] e, input int n);
    for (int i = 0; i < n; i++) begin
      host_u.rd(`OFS_RESP, d, r);
      chk("answer", d, {23'h0, 1'b1, e[8*(n-1-i) +: 8]});
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------
  // Scenarios
  // ----------------------------
  task automatic t_reset;
    chk("atten", atten_set, 32'h0);
    chk("thr", detect_thr, 32'h0);
    host_u.rd(`OFS_MASK, d, r);
    chk("mask", d, 32'h0);
    host_u.rd(8'h14, d, r);
    chk("unmapped rresp", r, 32'h2);
    host_u.wr(8'h18, 32'h1, r);
    chk("unmapped bresp", r, 32'h2);
  endtask
  // Nibble boundaries 0 and 15 in both halves
  task automatic t_atten;
    logic [7:0] a;
    for (int i = 0; i < 4; i++) begin
      a = {4'(15 - 5*i), 4'(5*i)};
      host_u.send(`OP_SET_ATT, pr[i], a, 1);
      ans({8'h0, `OP_SET_ATT, pr[i], `ACK_OK, `BYTE_CR}, 4);
      chk("atten slot", atten_set[8*i +: 8], a);
      host_u.send(`OP_GET_ATT, pr[i], 8'h0, 0);
      ans({`OP_GET_ATT, pr[i], a, `ACK_OK, `BYTE_CR}, 5);
    end
    host_u.send(`OP_SET_ATT, 8'h21, 8'h11, 1);
    ans({8'h0, `OP_SET_ATT, 8'h21, `ACK_REJ, `BYTE_CR}, 4);
    chk("atten kept", atten_set, 32'h0F5AA5F0);
  endtask
  task automatic t_detect;
    host_u.send(`OP_SET_DET, pr[0], 8'h14, 1);
    // Command byte while the answer is unread is refused and not parsed
    host_u.wr(`OFS_CMD, {24'h0, `OP_GET_ATT}, r);
    chk("busy bresp", r, 32'h2);
    ans({8'h0, `OP_SET_DET, pr[0], `ACK_OK, `BYTE_CR}, 4);
    host_u.send(`OP_SET_DET, pr[1], 8'h15, 1);
    ans({8'h0, `OP_SET_DET, pr[1], `ACK_REJ, `BYTE_CR}, 4);
    chk("thr", detect_thr, 32'h14);
    host_u.send(`OP_GET_DET, pr[0], 8'h0, 0);
    ans({`OP_GET_DET, pr[0], 8'h14, `ACK_OK, `BYTE_CR}, 5);
    host_u.send(`OP_GET_DET, 8'h90, 8'h0, 0);
    ans({`OP_GET_DET, 8'h90, 8'h0, `ACK_REJ, `BYTE_CR}, 5);
  endtask
  // Opcode where the carriage return belongs starts a new frame
  task automatic t_frame;
    host_u.wr(`OFS_CMD, {24'h0, `OP_GET_ATT}, r);
    host_u.wr(`OFS_CMD, {24'h0, pr[1]}, r);
    host_u.wr(`OFS_CMD, {24'h0, `OP_SET_DET}, r);
    host_u.wr(`OFS_CMD, {24'h0, pr[1]}, r);
    host_u.wr(`OFS_CMD, {24'h0, 8'h07}, r);
    host_u.wr(`OFS_CMD, {24'h0, `BYTE_CR}, r);
    ans({8'h0, `OP_SET_DET, pr[1], `ACK_OK, `BYTE_CR}, 4);
    chk("thr slot1", detect_thr[9:5], 32'h7);
    host_u.rd(`OFS_STAT, d, r);
    chk("frame err", d[1], 32'h1);
    host_u.wr(`OFS_STAT, 32'h7, r);
  endtask
  task automatic t_irq;
    host_u.wr(`OFS_MASK, 32'h1, r);
    host_u.send(`OP_GET_DET, pr[1], 8'h0, 0);
    chk("irq set", irq, 32'h1);
    ans({`OP_GET_DET, pr[1], 8'h07, `ACK_OK, `BYTE_CR}, 5);
    host_u.wr(`OFS_STAT, 32'h1, r);
    chk("irq clear", irq, 32'h0);
  endtask
  task automatic pulse(input logic [1:0] p, input logic [4:0] l, input logic e);
    @(posedge aclk);
    tag_valid <= 1'b1;
    tag_proto <= p;
    tag_level <= l;
    tag_data <= {3'h5, l};
    @(posedge aclk);
    tag_valid <= 1'b0;
    #1;
    chk("fwd", fwd_valid, {31'h0, e});
    if (e) chk("fwd data", fwd_data, {24'h0, 3'h5, l});
  endtask
  // Equal level held back, one above passes
  task automatic t_gate;
    pulse(2'd1, 5'd7, 1'b0);
    pulse(2'd1, 5'd8, 1'b1);
    pulse(2'd3, 5'd0, 1'b0);
    pulse(2'd3, 5'd1, 1'b1);
    pulse(2'd0, 5'h14, 1'b0);
  endtask
  // ----------------------------
  // Clock, reset, run
  // ----------------------------
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    #400000;
    n_errors++;
    end_of_test;
  end
  initial begin
    {aresetn, tag_valid, tag_proto, tag_level, tag_data} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_atten;
    t_detect;
    t_frame;
    t_irq;
    t_gate;
    end_of_test;
  end
endmodule
`default_nettype wire
